// File: pkg/power_down_pkg.sv
package power_down_pkg;

    // ************************************************************
    // Timing counts
    // ************************************************************
    localparam logic [3:0] MC_CLKS          = 4'hc;
    localparam logic [7:0] RESET_MC_CYCLES  = 8'h02;

    // ************************************************************
    // Status line thresholds on a 10-bit converter code
    // ************************************************************
    localparam logic [9:0] STATUS_NORMAL_CODE = 10'h332;
    localparam logic [9:0] STATUS_LOW_CODE    = 10'h2cc;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [5:0] {
        ST_RUN      = 6'h01,
        ST_PD_RESET = 6'h02,
        ST_OSC_STOP = 6'h04,
        ST_PORT_HIZ = 6'h08,
        ST_SLEEP    = 6'h10,
        ST_WAKE     = 6'h20
    } pd_state_t;

    typedef struct packed {
        logic core_reset;
        logic osc_enable;
        logic port_hiz;
        logic hard_sleep_state;
    } core_ctrl_t;

    typedef struct packed {
        logic       valid;
        logic [9:0] code;
    } status_sample_t;

endpackage : power_down_pkg

// File: design/hard_power_down_seq.sv
`timescale 1ns/1ps
`default_nettype none

module hard_power_down_seq #(
    parameter logic [3:0] MC_LEN    = power_down_pkg::MC_CLKS,
    parameter logic [7:0] RESET_MCS = power_down_pkg::RESET_MC_CYCLES,
    parameter logic [9:0] NORM_CODE = power_down_pkg::STATUS_NORMAL_CODE,
    parameter logic [9:0] LOW_CODE  = power_down_pkg::STATUS_LOW_CODE
) (
    input  wire logic                            sys_clk,
    input  wire logic                            arst_n,
    input  wire logic                            power_down_request_n,
    input  wire logic                            ext_reset_n,
    input  wire power_down_pkg::status_sample_t  status_sense_input,
    input  wire logic                            save_done,
    output var  power_down_pkg::core_ctrl_t      core_ctrl,
    output logic                                 regulator_hold_output,
    output logic                                 standby_pending,
    output logic                                 program_start
);
    import power_down_pkg::*;

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    generate
        if (MC_LEN < 4'h2) begin : g_bad_mc
            $error("Machine cycle must span at least two clocks.");
        end
        if (RESET_MCS == 8'h00) begin : g_bad_rst
            $error("Reset phase must last at least one machine cycle.");
        end
        if (LOW_CODE >= NORM_CODE) begin : g_bad_thr
            $error("Low status code must lie below the normal code.");
        end
    endgenerate

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        pd_state_t  st;
        logic       req_meta;
        logic       req_sync;
        logic       rst_meta;
        logic       rst_sync;
        logic [3:0] mc_cnt;
        logic [7:0] phase_cnt;
        logic       hold;
        logic       pending;
        logic       start;
        core_ctrl_t ctrl;
    } seq_state_t;

    localparam seq_state_t STATE_RST = '{
        st:        ST_RUN,
        req_meta:  1'b1,
        req_sync:  1'b1,
        rst_meta:  1'b1,
        rst_sync:  1'b1,
        mc_cnt:    4'h0,
        phase_cnt: 8'h00,
        hold:      1'b0,
        pending:   1'b0,
        start:     1'b0,
        ctrl:      '{core_reset: 1'b0, osc_enable: 1'b1,
                     port_hiz: 1'b0, hard_sleep_state: 1'b0}
    };

    seq_state_t state_ff;
    seq_state_t nxt_state;
    logic       mc_tick;

    // The divider only runs while the oscillator is enabled.
    assign mc_tick = state_ff.ctrl.osc_enable
                     && (state_ff.mc_cnt == MC_LEN - 4'h1);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_state.start = 1'b0;
        // Only the second stage is read by any logic.
        nxt_state.req_meta = power_down_request_n;
        nxt_state.req_sync = state_ff.req_meta;
        nxt_state.rst_meta = ext_reset_n;
        nxt_state.rst_sync = state_ff.rst_meta;

        if (!state_ff.ctrl.osc_enable || mc_tick) begin
            nxt_state.mc_cnt = 4'h0;
        end else begin
            nxt_state.mc_cnt = state_ff.mc_cnt + 4'h1;
        end

        unique case (state_ff.st)
            ST_RUN: begin
                if (!state_ff.rst_sync) begin
                    nxt_state.st = ST_WAKE;
                    nxt_state.phase_cnt = 8'h00;
                    nxt_state.ctrl.core_reset = 1'b1;
                end else if (mc_tick && !state_ff.req_sync) begin
                    nxt_state.st = ST_PD_RESET;
                    nxt_state.phase_cnt = 8'h00;
                    nxt_state.ctrl.core_reset = 1'b1;
                end
            end
            ST_PD_RESET: begin
                if (!state_ff.rst_sync) begin
                    nxt_state.st = ST_WAKE;
                    nxt_state.phase_cnt = 8'h00;
                end else if (mc_tick) begin
                    nxt_state.phase_cnt = state_ff.phase_cnt + 8'h01;
                    if (state_ff.phase_cnt == RESET_MCS - 8'h01) begin
                        nxt_state.st = ST_OSC_STOP;
                        nxt_state.ctrl.osc_enable = 1'b0;
                    end
                end
            end
            ST_OSC_STOP: begin
                // Ports float only after the clock has stopped.
                nxt_state.st = ST_PORT_HIZ;
                nxt_state.ctrl.port_hiz = 1'b1;
            end
            ST_PORT_HIZ: begin
                nxt_state.st = ST_SLEEP;
                nxt_state.ctrl.hard_sleep_state = 1'b1;
            end
            ST_SLEEP: begin
                // No machine cycles exist here, so wake is level driven.
                if (!state_ff.rst_sync || state_ff.req_sync) begin
                    nxt_state.st = ST_WAKE;
                    nxt_state.phase_cnt = 8'h00;
                    nxt_state.ctrl = '{core_reset: 1'b1,
                                       osc_enable: 1'b1,
                                       port_hiz: 1'b0,
                                       hard_sleep_state: 1'b0};
                end
            end
            ST_WAKE: begin
                // The reset sequence is held while the reset pin is low.
                if (!state_ff.rst_sync) begin
                    nxt_state.phase_cnt = 8'h00;
                end else if (mc_tick) begin
                    nxt_state.phase_cnt = state_ff.phase_cnt + 8'h01;
                    if (state_ff.phase_cnt == RESET_MCS - 8'h01) begin
                        nxt_state.st = ST_RUN;
                        nxt_state.ctrl.core_reset = 1'b0;
                        nxt_state.start = 1'b1;
                        nxt_state.hold = 1'b0;
                        nxt_state.pending = 1'b0;
                    end
                end
            end
        endcase

        // Firmware duties run only while code executes.
        if (state_ff.st == ST_RUN && !state_ff.ctrl.core_reset) begin
            if (status_sense_input.valid) begin
                if (status_sense_input.code >= NORM_CODE) begin
                    nxt_state.pending = 1'b0;
                end else if (status_sense_input.code < LOW_CODE) begin
                    nxt_state.pending = 1'b1;
                end
            end
            // Hold stays low through the save; done only switches it on.
            if (state_ff.pending && save_done) begin
                nxt_state.hold = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= STATE_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign core_ctrl             = state_ff.ctrl;
    assign regulator_hold_output = state_ff.hold;
    assign standby_pending       = state_ff.pending;
    assign program_start         = state_ff.start;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    a_entry_on_sample: assert property (
        state_ff.st == ST_RUN && state_ff.rst_sync && mc_tick
        && !state_ff.req_sync |=> state_ff.st == ST_PD_RESET)
        else $error("Low request sample did not start power-down.");

    a_no_entry_off_tick: assert property (
        state_ff.st == ST_RUN && !mc_tick |=> state_ff.st != ST_PD_RESET)
        else $error("Power-down entered outside a machine cycle sample.");

    a_entry_order: assert property (
        state_ff.st == ST_OSC_STOP |=> !core_ctrl.osc_enable
        && core_ctrl.port_hiz ##1 core_ctrl.hard_sleep_state)
        else $error("Oscillator stop and tri-state out of order.");

    a_reset_first: assert property (
        $rose(core_ctrl.port_hiz) |-> $past(core_ctrl.core_reset, 2)
        && !$past(core_ctrl.osc_enable))
        else $error("Ports floated without reset phase and stopped clock.");

    a_wake_request: assert property (
        state_ff.st == ST_SLEEP && state_ff.req_sync
        |=> state_ff.st == ST_WAKE && core_ctrl.osc_enable)
        else $error("High request did not wake the device.");

    a_wake_reset: assert property (
        state_ff.st == ST_SLEEP && !state_ff.rst_sync
        |=> state_ff.st == ST_WAKE && !core_ctrl.port_hiz)
        else $error("Reset did not wake the device.");

    a_reset_wins: assert property (
        state_ff.st == ST_RUN && !state_ff.rst_sync
        |=> state_ff.st == ST_WAKE)
        else $error("Power-down taken while reset was active.");

    a_wake_sequence: assert property (
        $rose(program_start) |-> $past(state_ff.st) == ST_WAKE
        && !core_ctrl.core_reset && state_ff.st == ST_RUN)
        else $error("Execution began without the reset sequence.");

    a_hold_set: assert property (
        state_ff.st == ST_RUN && !core_ctrl.core_reset
        && standby_pending && save_done |=> regulator_hold_output)
        else $error("Hold output not raised after data save.");

    a_hold_low_save: assert property (
        $rose(regulator_hold_output) |-> $past(save_done)
        && $past(standby_pending))
        else $error("Hold output rose before the save completed.");

    a_hold_cleared: assert property (
        program_start |-> !regulator_hold_output)
        else $error("Hold output not cleared at restart.");

    a_status_low: assert property (
        state_ff.st == ST_RUN && !core_ctrl.core_reset
        && status_sense_input.valid
        && status_sense_input.code < LOW_CODE |=> standby_pending)
        else $error("Low status level not flagged.");

    a_sync_path: assert property (
        state_ff.req_sync == $past(power_down_request_n, 2)
        || !$past(arst_n, 2))
        else $error("Request sync path not two stages.");

    c_enter_sleep: cover property (
        state_ff.st == ST_PORT_HIZ ##1 state_ff.st == ST_SLEEP);
    c_wake_by_req: cover property (
        state_ff.st == ST_SLEEP && state_ff.req_sync && state_ff.rst_sync);
    c_wake_by_rst: cover property (
        state_ff.st == ST_SLEEP && !state_ff.rst_sync);
    c_save_cycle: cover property (
        standby_pending ##[1:50] $rose(regulator_hold_output));

endmodule : hard_power_down_seq

`default_nettype wire

// File: testbench/regulator_model.sv
`timescale 1ns/1ps
`default_nettype none

module regulator_model (
    input  wire logic sys_clk,
    input  wire logic supply_ok,
    input  wire logic regulator_hold_output,
    output logic      power_down_request_n
);
    // ****************************************
    // Main path and reset output
    // ****************************************
    // The reset output lags the main path by two cycles, as a real
    // supervisor never reacts in the cycle the supply changes.
    logic [1:0] path_ff = 2'h3;

    always_ff @(posedge sys_clk) begin
        path_ff <= {path_ff[0], supply_ok | ~regulator_hold_output};
    end

    assign power_down_request_n = path_ff[1];
endmodule : regulator_model

`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    import power_down_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic           sys_clk;
    logic           arst_n;
    logic           ext_reset_n;
    logic           save_done;
    logic           supply_ok;
    logic           power_down_request_n;
    logic           regulator_hold_output;
    logic           standby_pending;
    logic           program_start;
    status_sample_t status_sense_input;
    core_ctrl_t     core_ctrl;
    int             failures;
    int             n_tests;
    int             cyc;
    int             seed;
    int             exp_pend;
    int             exp_hold;
    int             exp_q[$];
    logic [9:0]     codes[6];

    hard_power_down_seq dut_u (
        .sys_clk               (sys_clk),
        .arst_n                (arst_n),
        .power_down_request_n  (power_down_request_n),
        .ext_reset_n           (ext_reset_n),
        .status_sense_input    (status_sense_input),
        .save_done             (save_done),
        .core_ctrl             (core_ctrl),
        .regulator_hold_output (regulator_hold_output),
        .standby_pending       (standby_pending),
        .program_start         (program_start)
    );

    regulator_model reg_u (
        .sys_clk               (sys_clk),
        .supply_ok             (supply_ok),
        .regulator_hold_output (regulator_hold_output),
        .power_down_request_n  (power_down_request_n)
    );

    // ****************************************
    // Clock, timeout and helpers
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc > 2000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    function automatic logic sig(input int sel);
        case (sel)
            0:       return core_ctrl.core_reset;
            1:       return core_ctrl.hard_sleep_state;
            default: return program_start;
        endcase
    endfunction : sig

    task automatic wait_for(input int sel, input logic val);
        for (int k = 0; k < 60; k++) begin
            if (sig(sel) === val) return;
            tick(1);
        end
        chk(16'(sig(sel)), 16'(val));
    endtask : wait_for

    task automatic fw(input logic [9:0] code);
        @(posedge sys_clk);
        status_sense_input <= '{valid: 1'b1, code: code};
        @(posedge sys_clk);
        status_sense_input.valid <= 1'b0;
        #1;
        if (code >= STATUS_NORMAL_CODE) exp_pend = 0;
        else if (code < STATUS_LOW_CODE) exp_pend = 1;
        chk({15'h0, standby_pending}, 16'(exp_pend));
    endtask : fw

    task automatic pulse_save;
        @(posedge sys_clk);
        save_done <= 1'b1;
        @(posedge sys_clk);
        save_done <= 1'b0;
        #1;
        if (exp_pend == 1) exp_hold = 1;
    endtask : pulse_save

    task automatic prepare_standby;
        @(posedge sys_clk);
        supply_ok <= 1'b0;
        fw(codes[0]);
        chk({15'h0, regulator_hold_output}, 16'h0);
        pulse_save();
        chk({15'h0, regulator_hold_output}, 16'(exp_hold));
        wait_for(0, 1'b1);
    endtask : prepare_standby

    task automatic enter_sleep;
        prepare_standby();
        // Two machine cycles of reset, then clock stop, float and sleep.
        for (int k = 1; k < 24; k++) begin
            exp_q.push_back(32'hc);
        end
        exp_q.push_back(32'h8);
        exp_q.push_back(32'ha);
        exp_q.push_back(32'hb);
        while (exp_q.size() > 0) begin
            tick(1);
            chk(16'(core_ctrl), 16'(exp_q.pop_front()));
        end
    endtask : enter_sleep

    task automatic finish_wake;
        wait_for(2, 1'b1);
        chk(16'(core_ctrl), 16'h0004);
        tick(1);
        exp_pend = 0;
        exp_hold = 0;
        chk({14'h0, regulator_hold_output, standby_pending}, 16'h0);
    endtask : finish_wake

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        arst_n = 1'b0;
        ext_reset_n = 1'b1;
        save_done = 1'b0;
        supply_ok = 1'b1;
        status_sense_input = '0;
        seed = 65;
        codes = '{10'h000, 10'h300, STATUS_NORMAL_CODE, 10'h2cb,
                  STATUS_LOW_CODE, 10'h3ff};
        codes[0] = 10'($unsigned($random(seed)) % 32'h2cc);
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        tick(1);
        chk({12'h0, core_ctrl}, 16'h0004);
        pulse_save();
        chk({15'h0, regulator_hold_output}, 16'h0);
        foreach (codes[i]) fw(codes[i]);
        chk({15'h0, regulator_hold_output}, 16'h0);
        enter_sleep();
        @(posedge sys_clk);
        supply_ok <= 1'b1;
        wait_for(1, 1'b0);
        chk(16'(core_ctrl), 16'h000c);
        finish_wake();
        enter_sleep();
        // Request stays low here, so only reset priority can wake it.
        @(posedge sys_clk);
        ext_reset_n <= 1'b0;
        wait_for(1, 1'b0);
        tick(40);
        chk(16'(core_ctrl), 16'h000c);
        @(posedge sys_clk);
        supply_ok <= 1'b1;
        ext_reset_n <= 1'b1;
        finish_wake();
        // Reset during the reset phase keeps the clock running: no sleep.
        prepare_standby();
        @(posedge sys_clk);
        ext_reset_n <= 1'b0;
        tick(40);
        chk(16'(core_ctrl), 16'h000c);
        // Request is still low at release; the cleared hold lifts it in time.
        @(posedge sys_clk);
        ext_reset_n <= 1'b1;
        finish_wake();
        tick(20);
        chk(16'(core_ctrl), 16'h0004);
        // Reset while running takes the device straight into its reset.
        @(posedge sys_clk);
        ext_reset_n <= 1'b0;
        wait_for(0, 1'b1);
        chk(16'(core_ctrl), 16'h000c);
        @(posedge sys_clk);
        ext_reset_n <= 1'b1;
        finish_wake();
        wrap_up();
    end
endmodule : tb

`default_nettype wire
